// file: hdl/sem_pkg.sv
/*
 * Package for the status event mask and message queue block: command codes,
 * bit positions, reset values and queue constants.
 * Assumes a single 40 MHz clock domain and a host-side command decoder.
 */
package sem_pkg;

    // ----------------------------------------------------------------------
    // Widths and queue sizing
    // ----------------------------------------------------------------------
    localparam int unsigned REG_W      = 16;
    localparam int unsigned CODE_W     = 16;
    localparam int unsigned QUEUE_DEPTH = 10;

    localparam logic [REG_W-1:0]  MASK_RESET     = 16'h0000;
    localparam logic [REG_W-1:0]  MASK_ALL       = 16'hFFFF;
    localparam logic [CODE_W-1:0] CODE_NO_ERROR  = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_OVERFLOW  = 16'h015E;

    // ----------------------------------------------------------------------
    // Live status bit positions, measurement set
    // ----------------------------------------------------------------------
    localparam int unsigned MEAS_READING_OVERRANGE   = 0;
    localparam int unsigned MEAS_LOWER_LIMIT_ONE     = 1;
    localparam int unsigned MEAS_UPPER_LIMIT_ONE     = 2;
    localparam int unsigned MEAS_LOWER_LIMIT_TWO     = 3;
    localparam int unsigned MEAS_UPPER_LIMIT_TWO     = 4;
    localparam int unsigned MEAS_READING_READY       = 5;
    localparam int unsigned MEAS_BUFFER_HAS_READINGS = 7;
    localparam int unsigned MEAS_BUFFER_HALF_FLAG    = 8;
    localparam int unsigned MEAS_BUFFER_FULL_FLAG    = 9;
    localparam logic [REG_W-1:0] MEAS_USED = 16'h03BF;

    // Questionable set
    localparam int unsigned QUES_JUNCTION_FAULT = 4;
    localparam int unsigned QUES_CONSTANT_FAULT = 8;
    localparam int unsigned QUES_SELF_TRIM_FAULT = 9;
    localparam logic [REG_W-1:0] QUES_USED = 16'h0310;

    // Operation set
    localparam int unsigned OPER_TRIMMING   = 0;
    localparam int unsigned OPER_CONVERTING = 4;
    localparam int unsigned OPER_ARM_WAIT   = 5;
    localparam int unsigned OPER_SETTLED    = 8;
    localparam int unsigned OPER_IDLE       = 10;
    localparam logic [REG_W-1:0] OPER_USED = 16'h0531;

    // ----------------------------------------------------------------------
    // Register set select and host commands
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEM_SET_MEAS,
        SEM_SET_QUES,
        SEM_SET_OPER,
        SEM_SET_NONE
    } sem_set_t;

    typedef enum logic [2:0] {
        SEM_CMD_NOP,
        SEM_CMD_MASK_WRITE,
        SEM_CMD_MASK_READ,
        SEM_CMD_EVENT_READ,
        SEM_CMD_COND_READ,
        SEM_CMD_PRESET,
        SEM_CMD_QUEUE_NEXT,
        SEM_CMD_SYS_ERROR
    } sem_cmd_t;

endpackage : sem_pkg

// file: hdl/sem_queue_if.sv
/*
 * Interface carrying push and pop traffic between the status core and the
 * message queue.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
interface sem_queue_if;
    import sem_pkg::*;

    logic              push;
    logic [CODE_W-1:0] push_code;
    logic              pop;
    logic [CODE_W-1:0] head_code;
    logic              empty;
    logic              full;

    modport core (output push, output push_code, output pop,
                  input head_code, input empty, input full);
    modport queue (input push, input push_code, input pop,
                   output head_code, output empty, output full);
endinterface : sem_queue_if

// file: hdl/sem_msg_queue.sv
/*
 * First-in first-out store of signed message codes with an overflow marker.
 * Assumes at most one push and one pop per enabled cycle.
 */
`timescale 1ns/10ps
module sem_msg_queue #(
    parameter int unsigned DEPTH = sem_pkg::QUEUE_DEPTH
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic clk_en,
    sem_queue_if.queue q
);
    import sem_pkg::*;

    localparam int unsigned PW = $clog2(DEPTH + 1);

    // Refused at elaboration: the overflow marker needs a slot of its own
    if (DEPTH < 2) begin : g_depth_check
        $error("sem_msg_queue needs DEPTH of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][CODE_W-1:0] slot;
        logic [PW-1:0]                count;
    } sem_queue_state_t;

    sem_queue_state_t st_reg;
    sem_queue_state_t st_next;

    // Entry 0 is always the oldest; a pop shifts every slot down one.
    always_comb begin
        st_next = st_reg;
        if (q.pop && st_reg.count != '0) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                st_next.slot[i] = st_reg.slot[i+1];
            end
            st_next.slot[DEPTH-1] = CODE_NO_ERROR;
            st_next.count = st_reg.count - PW'(1);
        end
        if (q.push && st_next.count < PW'(DEPTH)) begin
            // Last free slot takes the overflow marker instead
            if (st_next.count == PW'(DEPTH - 1)) begin
                st_next.slot[st_next.count] = CODE_OVERFLOW;
            end else begin
                st_next.slot[st_next.count] = q.push_code;
            end
            st_next.count = st_next.count + PW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign q.head_code = (st_reg.count == '0) ? CODE_NO_ERROR : st_reg.slot[0];
    assign q.empty     = (st_reg.count == '0);
    assign q.full      = (st_reg.count == PW'(DEPTH));

    a_queue_bound: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.count <= PW'(DEPTH)) else $error("queue count above depth");
    a_overflow_last: assert property (@(posedge clock) disable iff (!nrst)
        (st_reg.count == PW'(DEPTH)) |-> st_reg.slot[DEPTH-1] == CODE_OVERFLOW)
        else $error("full queue lacks overflow marker");

endmodule : sem_msg_queue

// file: hdl/sem_status.sv
/*
 * Status reporting core: condition mirrors, latched event registers, enable
 * masks with summary outputs, and the host command port to the message queue.
 * Assumes the host presents one command per cycle with cmd_valid, all inputs
 * synchronous to clock.
 */
// Behaviour
// - Mask write loads the given 16-bit pattern; 0 clears all, 65535 sets all.
// - A zero mask bit keeps its event bit from the summary output.
// - A set mask bit with a set event bit raises the summary output.
// - Measurement layout: bits 9,8,7,5,4,3,2,1,0 used; 6 and 15..10 unused.
// - Questionable layout: bit 9 self-trim, 8 constant, 4 junction fault.
// - Operation layout: bit 10 idle, 8 settled, 5 arm wait, 4 convert, 0 trim.
// - Condition registers mirror live status without latching.
// - Condition query returns the register content as a binary word.
// - Preset clears all three enable masks.
// - Preset leaves events, conditions and the queue untouched.
// - Queue is first in first out; a read pops the oldest entry.
// - Queue holds at most ten entries.
// - On filling, the last slot holds code 350, the overflow marker.
// - Queue is empty after reset.
// - Reading an empty queue yields code 0.
// - Codes are signed: negative standard, positive vendor defined.
// - Status-queue read and system error read behave the same.
// - Reading an event register returns it and then clears it.
`timescale 1ns/10ps
module sem_status (
    input  wire logic                          clock,
    input  wire logic                          nrst,
    input  wire logic                          clk_en,
    input  wire logic                          cmd_valid,
    input  wire sem_pkg::sem_cmd_t             cmd,
    input  wire sem_pkg::sem_set_t             cmd_set,
    input  wire logic [sem_pkg::REG_W-1:0]     cmd_data,
    input  wire logic [sem_pkg::REG_W-1:0]     meas_live,
    input  wire logic [sem_pkg::REG_W-1:0]     ques_live,
    input  wire logic [sem_pkg::REG_W-1:0]     oper_live,
    input  wire logic                          msg_valid,
    input  wire logic signed [sem_pkg::CODE_W-1:0] msg_code,
    output logic                               rsp_valid,
    output logic [sem_pkg::REG_W-1:0]          rsp_data,
    output logic                               meas_summary,
    output logic                               ques_summary,
    output logic                               oper_summary,
    output logic                               queue_empty
);
    import sem_pkg::*;

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic [REG_W-1:0] meas_event_mask;
        logic [REG_W-1:0] questionable_event_mask;
        logic [REG_W-1:0] operation_event_mask;
        logic [REG_W-1:0] meas_cond;
        logic [REG_W-1:0] ques_cond;
        logic [REG_W-1:0] oper_cond;
        logic [REG_W-1:0] meas_evt;
        logic [REG_W-1:0] ques_evt;
        logic [REG_W-1:0] oper_evt;
        logic             rsp_valid;
        logic [REG_W-1:0] rsp_data;
        logic             meas_sum;
        logic             ques_sum;
        logic             oper_sum;
        logic             q_empty;
    } sem_state_t;

    sem_state_t st_reg;
    sem_state_t st_next;

    sem_queue_if qif ();

    sem_msg_queue #(
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clock  (clock),
        .nrst   (nrst),
        .clk_en (clk_en),
        .q      (qif.queue)
    );

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic logic [REG_W-1:0] sem_pick(input sem_set_t s,
                                                  input logic [REG_W-1:0] m,
                                                  input logic [REG_W-1:0] q,
                                                  input logic [REG_W-1:0] o);
        logic [REG_W-1:0] r;
        r = '0;
        unique case (s)
            SEM_SET_MEAS: r = m;
            SEM_SET_QUES: r = q;
            SEM_SET_OPER: r = o;
            SEM_SET_NONE: r = '0;
        endcase
        return r;
    endfunction : sem_pick

    // Rising edge of each used live bit, after the used-bit filter
    function automatic logic [REG_W-1:0] sem_rise(input logic [REG_W-1:0] live,
                                                  input logic [REG_W-1:0] cond,
                                                  input logic [REG_W-1:0] used);
        return live & used & ~cond;
    endfunction : sem_rise

    logic is_read;
    logic is_pop;

    // Signed codes pass unchanged; sign carries standard versus vendor origin
    assign qif.push      = msg_valid;
    assign qif.push_code = msg_code;
    assign is_pop        = cmd_valid && (cmd == SEM_CMD_QUEUE_NEXT || cmd == SEM_CMD_SYS_ERROR);
    assign qif.pop       = is_pop;
    assign is_read       = cmd_valid && (cmd == SEM_CMD_EVENT_READ);

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rsp_valid = 1'b0;

        // Condition mirrors, unused bits forced low
        st_next.meas_cond = meas_live & MEAS_USED;
        st_next.ques_cond = ques_live & QUES_USED;
        st_next.oper_cond = oper_live & OPER_USED;

        // A read clears its event register; a new edge in that cycle still sets
        if (is_read && cmd_set == SEM_SET_MEAS) begin
            st_next.meas_evt = '0;
        end
        if (is_read && cmd_set == SEM_SET_QUES) begin
            st_next.ques_evt = '0;
        end
        if (is_read && cmd_set == SEM_SET_OPER) begin
            st_next.oper_evt = '0;
        end
        st_next.meas_evt = st_next.meas_evt | sem_rise(meas_live, st_reg.meas_cond, MEAS_USED);
        st_next.ques_evt = st_next.ques_evt | sem_rise(ques_live, st_reg.ques_cond, QUES_USED);
        st_next.oper_evt = st_next.oper_evt | sem_rise(oper_live, st_reg.oper_cond, OPER_USED);

        if (cmd_valid) begin
            unique case (cmd)
                SEM_CMD_NOP: begin
                end
                SEM_CMD_MASK_WRITE: begin
                    if (cmd_set == SEM_SET_MEAS) begin
                        st_next.meas_event_mask = cmd_data;
                    end
                    if (cmd_set == SEM_SET_QUES) begin
                        st_next.questionable_event_mask = cmd_data;
                    end
                    if (cmd_set == SEM_SET_OPER) begin
                        st_next.operation_event_mask = cmd_data;
                    end
                end
                SEM_CMD_MASK_READ: begin
                    st_next.rsp_valid = 1'b1;
                    st_next.rsp_data  = sem_pick(cmd_set, st_reg.meas_event_mask,
                                                 st_reg.questionable_event_mask,
                                                 st_reg.operation_event_mask);
                end
                SEM_CMD_EVENT_READ: begin
                    st_next.rsp_valid = 1'b1;
                    st_next.rsp_data  = sem_pick(cmd_set, st_reg.meas_evt, st_reg.ques_evt,
                                                 st_reg.oper_evt);
                end
                SEM_CMD_COND_READ: begin
                    st_next.rsp_valid = 1'b1;
                    st_next.rsp_data  = sem_pick(cmd_set, st_reg.meas_cond, st_reg.ques_cond,
                                                 st_reg.oper_cond);
                end
                SEM_CMD_PRESET: begin
                    // Only the masks; events, conditions and queue stay put
                    st_next.meas_event_mask         = MASK_RESET;
                    st_next.questionable_event_mask = MASK_RESET;
                    st_next.operation_event_mask    = MASK_RESET;
                end
                SEM_CMD_QUEUE_NEXT, SEM_CMD_SYS_ERROR: begin
                    st_next.rsp_valid = 1'b1;
                    st_next.rsp_data  = qif.head_code;
                end
            endcase
        end

        // Summary is computed from the registered state, one cycle behind
        st_next.meas_sum = |(st_reg.meas_evt & st_reg.meas_event_mask);
        st_next.ques_sum = |(st_reg.ques_evt & st_reg.questionable_event_mask);
        st_next.oper_sum = |(st_reg.oper_evt & st_reg.operation_event_mask);
        st_next.q_empty  = qif.empty;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg         <= '0;
            st_reg.q_empty <= 1'b1;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign rsp_valid    = st_reg.rsp_valid;
    assign rsp_data     = st_reg.rsp_data;
    assign meas_summary = st_reg.meas_sum;
    assign ques_summary = st_reg.ques_sum;
    assign oper_summary = st_reg.oper_sum;
    assign queue_empty  = st_reg.q_empty;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    sequence s_mask_write_meas;
        clk_en && cmd_valid && cmd == SEM_CMD_MASK_WRITE && cmd_set == SEM_SET_MEAS;
    endsequence

    a_mask_load: assert property (@(posedge clock) disable iff (!nrst)
        s_mask_write_meas |=> st_reg.meas_event_mask == $past(cmd_data))
        else $error("measurement mask not loaded");
    a_masked_quiet: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && (st_reg.oper_evt & st_reg.operation_event_mask) == '0 |=> !oper_summary)
        else $error("masked event raised summary");
    a_summary_rise: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && (st_reg.meas_evt & st_reg.meas_event_mask) != '0 |=> meas_summary)
        else $error("unmasked event missed summary");
    a_unused_low: assert property (@(posedge clock) disable iff (!nrst)
        (st_reg.meas_evt & ~MEAS_USED) == '0 && (st_reg.ques_evt & ~QUES_USED) == '0)
        else $error("unused event bit set");
    a_oper_unused: assert property (@(posedge clock) disable iff (!nrst)
        (st_reg.oper_cond & ~OPER_USED) == '0) else $error("unused operation bit set");
    a_cond_mirror: assert property (@(posedge clock) disable iff (!nrst)
        clk_en |=> st_reg.ques_cond == ($past(ques_live) & QUES_USED))
        else $error("condition does not mirror live status");
    a_cond_reply: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && cmd_valid && cmd == SEM_CMD_COND_READ && cmd_set == SEM_SET_OPER
        |=> rsp_valid && rsp_data == $past(st_reg.oper_cond))
        else $error("condition reply wrong");
    a_preset_clear: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && cmd_valid && cmd == SEM_CMD_PRESET |=> st_reg.meas_event_mask == '0
        && st_reg.questionable_event_mask == '0 && st_reg.operation_event_mask == '0
        && ($past(st_reg.meas_evt) & ~st_reg.meas_evt) == '0
        && ($past(st_reg.oper_evt) & ~st_reg.oper_evt) == '0)
        else $error("preset left a mask set or lost an event");
    a_empty_reply: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && is_pop && qif.empty |=> rsp_valid && rsp_data == CODE_NO_ERROR)
        else $error("empty queue did not answer zero");
    a_event_clear: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && is_read && cmd_set == SEM_SET_QUES && (ques_live & ~st_reg.ques_cond) == '0
        |=> st_reg.ques_evt == '0) else $error("event read did not clear");
    a_event_latch: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && meas_live[MEAS_BUFFER_FULL_FLAG] && !st_reg.meas_cond[MEAS_BUFFER_FULL_FLAG]
        |=> st_reg.meas_evt[MEAS_BUFFER_FULL_FLAG]) else $error("event did not latch");

endmodule : sem_status

// file: testbench/sem_host.sv
/*
 * Host model for the status block: issues one command at a time on the
 * command port, with a one-cycle strobe.
 * Assumes the caller enters each task just after a rising clock edge.
 */
`timescale 1ns/10ps
module sem_host (
    input  wire logic                      clock,
    output logic                           cmd_valid,
    output sem_pkg::sem_cmd_t              cmd,
    output sem_pkg::sem_set_t              cmd_set,
    output logic [sem_pkg::REG_W-1:0]      cmd_data
);
    import sem_pkg::*;

    initial begin
        cmd_valid = 1'b0;
        cmd       = SEM_CMD_NOP;
        cmd_set   = SEM_SET_NONE;
        cmd_data  = 16'h0000;
    end

    // Strobe drops one edge later; the idle gap keeps two writes out of one time step
    task automatic issue(input sem_cmd_t c, input sem_set_t s, input logic [REG_W-1:0] d);
        @(posedge clock);
        #2;
        cmd_valid = 1'b1;
        cmd       = c;
        cmd_set   = s;
        cmd_data  = d;
        @(posedge clock);
        #2;
        cmd_valid = 1'b0;
        cmd       = SEM_CMD_NOP;
        cmd_data  = ~d;
    endtask : issue
endmodule : sem_host

// file: testbench/status_event_mask_and_error_queue_tb.sv
/*
 * Self-checking bench for sem_status: masks, conditions, events, preset and
 * the message queue, with answers checked off a queue of expected words.
 * Assumes read answers arrive on the edge that takes the command.
 */
`timescale 1ns/10ps
module status_event_mask_and_error_queue_tb;
    import sem_pkg::*;

    logic                     clock;
    logic                     nrst;
    logic                     clk_en;
    logic                     cmd_valid;
    sem_cmd_t                 cmd;
    sem_set_t                 cmd_set;
    logic [REG_W-1:0]         cmd_data;
    logic [REG_W-1:0]         live [3];
    logic                     msg_valid;
    logic signed [CODE_W-1:0] msg_code;
    logic                     rsp_valid;
    logic [REG_W-1:0]         rsp_data;
    logic [2:0]               summ;
    logic                     queue_empty;
    logic [REG_W-1:0]         exp_q [$];
    logic [REG_W-1:0]         rnd;
    logic [REG_W-1:0]         v;
    int                       errors;
    int                       checks_done;
    localparam logic [REG_W-1:0] USED [3] = '{MEAS_USED, QUES_USED, OPER_USED};

    sem_host u_sem_host (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_set(cmd_set), .cmd_data(cmd_data));

    sem_status u_sem_status (.clock(clock), .nrst(nrst), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_set(cmd_set), .cmd_data(cmd_data), .meas_live(live[0]), .ques_live(live[1]), .oper_live(live[2]),
        .msg_valid(msg_valid), .msg_code(msg_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .meas_summary(summ[0]), .ques_summary(summ[1]), .oper_summary(summ[2]), .queue_empty(queue_empty));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Odd entries negative as standard codes, even ones positive as vendor codes
    function automatic logic [15:0] mcode(input int k);
        return (k % 2 == 1) ? 16'(-(100 + k)) : 16'(200 + k);
    endfunction : mcode

    task automatic fail(input string m);
        errors++;
        $display("[FAIL] %0t ns %s", $time, m);
    endtask : fail

    task automatic chk_lvl(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp) fail(m);
    endtask : chk_lvl

    task automatic cmp_rsp(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
        checks_done++;
        if (got !== exp) fail($sformatf("answer %h, expected %h", got, exp));
    endtask : cmp_rsp

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : cyc

    task automatic rd(input sem_cmd_t c, input sem_set_t s, input logic [REG_W-1:0] exp);
        exp_q.push_back(exp);
        u_sem_host.issue(c, s, 16'h0000);
    endtask : rd

    task automatic wr(input int s, input logic [REG_W-1:0] d);
        u_sem_host.issue(SEM_CMD_MASK_WRITE, sem_set_t'(s), d);
    endtask : wr

    task automatic push_msg(input logic [CODE_W-1:0] c);
        @(posedge clock);
        #2;
        msg_valid = 1'b1;
        msg_code  = c;
        @(posedge clock);
        #2;
        msg_valid = 1'b0;
        msg_code  = ~c;
    endtask : push_msg

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // Answers are looked at mid-cycle, away from the edge that launches them
    always @(negedge clock) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) fail("answer with none pending");
            else cmp_rsp(rsp_data, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        fail("run timed out");
        give_verdict();
    end

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        nrst        = 1'b0;
        clk_en      = 1'b1;
        msg_valid   = 1'b0;
        msg_code    = 16'h0000;
        live        = '{default: 16'h0000};
        errors      = 0;
        checks_done = 0;
        rnd         = 16'h3A27; // Seed 14887
        repeat (12) @(posedge clock);
        #2;
        nrst = 1'b1;
        chk_lvl(queue_empty, 1'b1, "queue not empty after reset");
        chk_lvl(|summ, 1'b0, "summary set after reset");
        rd(SEM_CMD_QUEUE_NEXT, SEM_SET_NONE, CODE_NO_ERROR);
        for (int s = 0; s < 3; s++) begin
            for (int i = 0; i < 3; i++) begin
                v   = (i == 0) ? MASK_RESET : (i == 1) ? MASK_ALL : rnd;
                rnd = lfsr(rnd);
                wr(s, v);
                rd(SEM_CMD_MASK_READ, sem_set_t'(s), v);
            end
        end
        rd(SEM_CMD_MASK_READ, SEM_SET_NONE, 16'h0000);
        $display("test masks done");

        for (int s = 0; s < 3; s++) begin
            for (int p = 0; p < 2; p++) begin
                v   = (p == 0) ? rnd : MASK_ALL;
                rnd = lfsr(rnd);
                wr(s, MASK_RESET);
                live[s] = v;
                cyc(4);
                chk_lvl(summ[s], 1'b0, "masked event reached summary");
                rd(SEM_CMD_COND_READ, sem_set_t'(s), v & USED[s]);
                wr(s, v);
                cyc(3);
                chk_lvl(summ[s], |(v & USED[s]), "summary wrong with mask set");
                rd(SEM_CMD_EVENT_READ, sem_set_t'(s), v & USED[s]);
                rd(SEM_CMD_EVENT_READ, sem_set_t'(s), 16'h0000);
                cyc(3);
                chk_lvl(summ[s], 1'b0, "summary held after event read");
                live[s] = 16'h0000;
                cyc(3);
                rd(SEM_CMD_COND_READ, sem_set_t'(s), 16'h0000);
            end
        end
        $display("test events done");

        for (int s = 0; s < 3; s++) wr(s, MASK_ALL);
        push_msg(16'hFF9C);
        live[0] = USED[0];
        cyc(4);
        chk_lvl(summ[0], 1'b1, "summary missing before preset");
        u_sem_host.issue(SEM_CMD_PRESET, SEM_SET_NONE, 16'h0000);
        cyc(3);
        chk_lvl(summ[0], 1'b0, "summary survives preset");
        for (int s = 0; s < 3; s++) rd(SEM_CMD_MASK_READ, sem_set_t'(s), MASK_RESET);
        rd(SEM_CMD_COND_READ, SEM_SET_MEAS, USED[0]);
        rd(SEM_CMD_EVENT_READ, SEM_SET_MEAS, USED[0]);
        rd(SEM_CMD_QUEUE_NEXT, SEM_SET_NONE, 16'hFF9C);
        live[0] = 16'h0000;
        $display("test preset done");

        for (int k = 0; k < 12; k++) push_msg(mcode(k));
        cyc(2);
        chk_lvl(queue_empty, 1'b0, "queue empty after pushes");
        for (int k = 0; k < 11; k++) begin
            v = (k < 9) ? mcode(k) : (k == 9) ? CODE_OVERFLOW : CODE_NO_ERROR;
            rd(k % 2 == 1 ? SEM_CMD_SYS_ERROR : SEM_CMD_QUEUE_NEXT, SEM_SET_NONE, v);
        end
        cyc(2);
        chk_lvl(queue_empty, 1'b1, "queue not empty after drain");
        $display("test queue done");

        clk_en = 1'b0;
        u_sem_host.issue(SEM_CMD_MASK_READ, SEM_SET_MEAS, 16'h0000);
        push_msg(16'h0123);
        cyc(2);
        clk_en = 1'b1;
        cyc(2);
        chk_lvl(queue_empty, 1'b1, "push taken while frozen");
        rd(SEM_CMD_QUEUE_NEXT, SEM_SET_NONE, CODE_NO_ERROR);
        $display("test freeze done");

        push_msg(16'h0042);
        nrst = 1'b0;
        cyc(2);
        nrst = 1'b1;
        chk_lvl(queue_empty, 1'b1, "queue not empty after second reset");
        rd(SEM_CMD_QUEUE_NEXT, SEM_SET_NONE, CODE_NO_ERROR);
        $display("test reset done");

        for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge clock);
        if (exp_q.size() != 0) fail("answers missing");
        give_verdict();
    end
endmodule : status_event_mask_and_error_queue_tb
